// File: hdl/psq_pkg.sv
// Purpose: Shared constants and types for the program sequencer.
// Assumes: One 20 MHz system clock; APB register access with 32-bit data.
// Notes: Register offsets are indices; byte address is four times the index.
package psq_pkg;

  localparam int PSQ_CLK_PERIOD_NS = 50;
  localparam int PSQ_PHASES = 4;
  localparam int PSQ_INSTR_CYCLE_NS = PSQ_PHASES * PSQ_CLK_PERIOD_NS;

  localparam int PSQ_PC_W = 14;
  localparam int PSQ_BRANCH_W = 13;
  localparam int PSQ_STACK_DEPTH = 16;
  localparam int PSQ_NUM_IRQ = 6;

  // Register indices
  localparam logic [7:0] REG_BANK_POINTER = 8'h04;
  localparam logic [7:0] REG_PC_LOW_BYTE = 8'h06;
  localparam logic [7:0] REG_TABLE_POINTER_LOW = 8'h07;
  localparam logic [7:0] REG_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] REG_SEQ_STATUS = 8'h30;
  localparam logic [7:0] REG_PC_HIGH = 8'h31;

  localparam int BANK_SEL_BIT = 5;
  localparam logic [7:0] RST_BANK_POINTER = 8'h00;
  localparam logic [7:0] RST_TABLE_POINTER_LOW = 8'h00;
  localparam logic [7:0] RST_TABLE_HIGH_BYTE = 8'h00;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_EXT_IRQ0 = 14'h0004;
  localparam logic [13:0] VEC_TIMER0 = 14'h0008;
  localparam logic [13:0] VEC_TIMER1 = 14'h000C;
  localparam logic [13:0] VEC_EXT_IRQ1 = 14'h0010;
  localparam logic [13:0] VEC_UART = 14'h0014;
  localparam logic [13:0] VEC_TIMER2 = 14'h0018;
  localparam logic [5:0] LAST_PAGE = 6'h3F;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_TABLE = 2'h1,
    ST_DUMMY = 2'h2
  } psq_state_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SKIP = 3'h1,
    OP_JUMP = 3'h2,
    OP_CALL = 3'h3,
    OP_RETURN_SUB = 3'h4,
    OP_RETURN_INT = 3'h5,
    OP_TABLE_CUR = 3'h6,
    OP_TABLE_LAST = 3'h7
  } psq_op_e;

  // Source order is also acknowledge priority, lowest index first
  function automatic logic [13:0] psq_vector(input int idx);
    case (idx)
      0: psq_vector = VEC_EXT_IRQ0;
      1: psq_vector = VEC_TIMER0;
      2: psq_vector = VEC_TIMER1;
      3: psq_vector = VEC_EXT_IRQ1;
      4: psq_vector = VEC_UART;
      5: psq_vector = VEC_TIMER2;
      default: psq_vector = VEC_RESET;
    endcase
  endfunction

endpackage

// File: hdl/psq_sequencer.sv
// Purpose: Program counter, fetch sequencer, stack and table read unit.
// Assumes: Program ROM answers within the instruction cycle; core ops are
//   held stable and sampled on the last phase of the cycle.
// Notes: Registers reached over APB; byte address is four times the index.
// Behaviour
// - Four phases per instruction cycle
// - Fetch overlaps execute; transfers take two cycles
// - Counter increments after each fetch
// - True skip discards next word, dummy cycle
// - Low byte write jumps within page
// - Reset clears counter to zero
// - External input 0 vectors to 004H
// - Timer 0 overflow vectors to 008H
// - Timer 1 overflow vectors to 00CH
// - External input 1 vectors to 010H
// - Serial port interrupt vectors to 014H
// - Timer 2 overflow vectors to 018H
// - Two 8K banks chosen by bit 5
// - Call/jump: 13 code bits plus bank bit
// - Return reloads all 14 bits from stack
// - Current-page table read, bytes to destinations
// - Last-page table read forces upper ones
// - Pointer read/write, high byte read-only
// - Table reads take two instruction cycles
// - Sixteen-level hidden stack, push and pop
// - Full stack holds interrupts; call overwrites oldest
`timescale 1ns/1ps
module psq_sequencer
  import psq_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STACK_DEPTH = PSQ_STACK_DEPTH,
  parameter int NUM_IRQ = PSQ_NUM_IRQ
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program ROM port
  output logic [PSQ_PC_W-1:0] rom_addr,
  output logic rom_rd,
  input wire logic [15:0] rom_data,
  // Execution unit
  output logic [3:0] phase_onehot,
  output logic [15:0] instr_word,
  output logic exec_valid,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic skip_cond,
  input wire logic [PSQ_BRANCH_W-1:0] op_target,
  output logic [7:0] table_low_data,
  output logic table_low_we,
  // Interrupt sources, flags and enables kept outside
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_en,
  output logic [NUM_IRQ-1:0] irq_ack
);
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int CNT_W = $clog2(STACK_DEPTH + 1);
  localparam logic [CNT_W-1:0] STACK_FULL = CNT_W'(STACK_DEPTH);

  psq_state_e state;
  psq_state_e next_state;
  psq_op_e op;
  logic [1:0] phase;
  logic boundary;
  logic [PSQ_PC_W-1:0] pc;
  logic [PSQ_PC_W-1:0] next_pc;
  logic [PSQ_PC_W-1:0] next_rom_addr;
  logic [PSQ_PC_W-1:0] table_addr;
  logic [7:0] bank_pointer;
  logic [7:0] table_pointer_low;
  logic [7:0] table_high_byte;
  logic short_pend;
  logic [7:0] short_data;
  logic short_take;
  logic do_push;
  logic do_pop;
  logic [SP_W-1:0] sp;
  logic [CNT_W-1:0] depth;
  logic stack_full;
  logic [NUM_IRQ-1:0] irq_ready;
  logic [NUM_IRQ-1:0] irq_take;
  logic transfer;

  psq_stack_if #(.AW(SP_W), .DW(PSQ_PC_W)) stk ();

  psq_stack_mem #(.AW(SP_W), .DW(PSQ_PC_W)) u_stack (
    .ref_clk(ref_clk),
    .st(stk)
  );

  // ---------------- Phase generator ----------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign boundary = (phase == 2'h3);
  assign rom_rd = (phase == 2'h0);

  always_comb begin
    phase_onehot = 4'h0;
    phase_onehot[phase] = 1'b1;
  end

  // ---------------- APB slave ----------------
  logic [7:0] reg_idx;
  logic addr_hit;
  logic [7:0] rd_mux;
  logic apb_wr;

  assign reg_idx = paddr[9:2];
  assign pready = 1'b1;

  always_comb begin
    addr_hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    rd_mux = 8'h00;
    case (reg_idx)
      REG_BANK_POINTER: rd_mux = bank_pointer;
      REG_PC_LOW_BYTE: rd_mux = pc[7:0];
      REG_TABLE_POINTER_LOW: rd_mux = table_pointer_low;
      REG_TABLE_HIGH_BYTE: rd_mux = table_high_byte;
      REG_SEQ_STATUS: rd_mux = {short_pend, state, depth};
      REG_PC_HIGH: rd_mux = {2'h0, pc[13:8]};
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;
  assign apb_wr = psel && penable && pwrite && addr_hit;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bank_pointer <= RST_BANK_POINTER;
      table_pointer_low <= RST_TABLE_POINTER_LOW;
    end else if (apb_wr) begin
      if (reg_idx == REG_BANK_POINTER) begin
        bank_pointer <= pwdata[7:0];
      end
      if (reg_idx == REG_TABLE_POINTER_LOW) begin
        table_pointer_low <= pwdata[7:0];
      end
    end
  end

  // A write lands mid-cycle; the jump waits for the next boundary.
  // A new write in the consuming cycle stays pending for the next one.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      short_pend <= 1'b0;
      short_data <= 8'h00;
    end else if (apb_wr && reg_idx == REG_PC_LOW_BYTE) begin
      short_pend <= 1'b1;
      short_data <= pwdata[7:0];
    end else if (short_take) begin
      short_pend <= 1'b0;
    end
  end

  // ---------------- Interrupt gating ----------------
  assign stack_full = (depth == STACK_FULL);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      assign irq_ready[gi] = irq_req[gi] && irq_en[gi] && !stack_full;
    end
  endgenerate

  // ---------------- Sequencing ----------------
  assign op = psq_op_e'(op_code);
  assign exec_valid = (state == ST_FETCH);

  always_comb begin
    next_state = state;
    next_pc = pc;
    table_addr = {pc[13:8], table_pointer_low};
    do_push = 1'b0;
    do_pop = 1'b0;
    short_take = 1'b0;
    irq_take = '0;
    transfer = 1'b0;
    if (boundary) begin
      if (state == ST_TABLE) begin
        next_state = ST_FETCH;
      end else begin
        next_pc = pc + 14'h0001;
        next_state = ST_FETCH;
        if (exec_valid && op_valid) begin
          case (op)
            OP_SKIP: begin
              if (skip_cond) begin
                next_state = ST_DUMMY;
                transfer = 1'b1;
              end
            end
            OP_JUMP: begin
              next_pc = {bank_pointer[BANK_SEL_BIT], op_target};
              next_state = ST_DUMMY;
              transfer = 1'b1;
            end
            OP_CALL: begin
              do_push = 1'b1;
              next_pc = {bank_pointer[BANK_SEL_BIT], op_target};
              next_state = ST_DUMMY;
              transfer = 1'b1;
            end
            OP_RETURN_SUB, OP_RETURN_INT: begin
              do_pop = 1'b1;
              next_pc = stk.rd_data;
              next_state = ST_DUMMY;
              transfer = 1'b1;
            end
            OP_TABLE_CUR: begin
              next_state = ST_TABLE;
              transfer = 1'b1;
            end
            OP_TABLE_LAST: begin
              table_addr = {LAST_PAGE, table_pointer_low};
              next_state = ST_TABLE;
              transfer = 1'b1;
            end
            default: ;
          endcase
        end
        if (!transfer && short_pend) begin
          short_take = 1'b1;
          next_pc = {pc[13:8], short_data};
          next_state = ST_DUMMY;
        end else if (!transfer && (irq_ready != '0)) begin
          // Word fetched this cycle is dropped and refetched on return
          for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_ready[i]) begin
              irq_take = '0;
              irq_take[i] = 1'b1;
              next_pc = psq_vector(i);
            end
          end
          do_push = 1'b1;
          next_state = ST_DUMMY;
        end
      end
    end
  end

  // Table word and fetch share the one ROM port, never in the same cycle
  assign next_rom_addr = (next_state == ST_TABLE) ? table_addr : next_pc;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_DUMMY;
      pc <= VEC_RESET;
      rom_addr <= VEC_RESET;
    end else if (boundary) begin
      state <= next_state;
      pc <= next_pc;
      rom_addr <= next_rom_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      instr_word <= 16'h0000;
    end else if (boundary && state != ST_TABLE) begin
      instr_word <= rom_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      table_high_byte <= RST_TABLE_HIGH_BYTE;
      table_low_data <= 8'h00;
      table_low_we <= 1'b0;
    end else begin
      table_low_we <= 1'b0;
      if (boundary && state == ST_TABLE) begin
        table_high_byte <= rom_data[15:8];
        table_low_data <= rom_data[7:0];
        table_low_we <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= '0;
    end else begin
      irq_ack <= irq_take;
    end
  end

  // ---------------- Return stack ----------------
  // Circular store: a push when full overwrites the oldest entry.
  assign stk.wr_en = do_push;
  assign stk.wr_addr = sp;
  assign stk.wr_data = pc;
  assign stk.rd_addr = sp - SP_W'(1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sp <= '0;
      depth <= '0;
    end else if (do_push) begin
      sp <= sp + SP_W'(1);
      if (!stack_full) begin
        depth <= depth + CNT_W'(1);
      end
    end else if (do_pop) begin
      sp <= sp - SP_W'(1);
      if (depth != '0) begin
        depth <= depth - CNT_W'(1);
      end
    end
  end

endmodule // psq_sequencer

// File: hdl/psq_stack_if.sv
// Purpose: Link between the sequencer and its return-address store.
// Assumes: One clock; read data is registered in the store.
// Notes: Write and read addresses are driven by the sequencer.
`timescale 1ns/1ps
interface psq_stack_if #(
  parameter int AW = 4,
  parameter int DW = 14
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// File: hdl/psq_stack_mem.sv
// Purpose: Return-address store with registered read port.
// Assumes: Synchronous write, read data one clock after the address.
// Notes: Contents are not reset; the sequencer tracks valid depth.
`timescale 1ns/1ps
module psq_stack_mem #(
  parameter int AW = 4,
  parameter int DW = 14
) (
  input wire logic ref_clk,
  psq_stack_if.mem st
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (st.wr_en) begin
      mem[st.wr_addr] <= st.wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    st.rd_data <= mem[st.rd_addr];
  end
endmodule // psq_stack_mem

// File: sim/psq_rom_model.sv
// Purpose: Behavioural program ROM on the sequencer's fetch port.
// Assumes: Address is steady while the fetch strobe is high.
// Notes: Each word holds its own address, so any fetch is predictable.
`timescale 1ns/1ps
module psq_rom_model (
  input wire logic ref_clk,
  input wire logic rom_rd,
  input wire logic [13:0] rom_addr,
  output logic [15:0] rom_data
);
  // Registered answer: data exists only after the strobe, never sooner
  always_ff @(posedge ref_clk) begin
    if (rom_rd) rom_data <= {2'b10, rom_addr};
  end
endmodule // psq_rom_model

// File: sim/psq_sequencer_properties.sv
// Purpose: Port-level checks of the program sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ps
module psq_sequencer_properties
  import psq_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NUM_IRQ = PSQ_NUM_IRQ
) (
  input logic ref_clk,
  input logic nrst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [PSQ_PC_W-1:0] rom_addr,
  input logic rom_rd,
  input logic [15:0] rom_data,
  input logic [3:0] phase_onehot,
  input logic [15:0] instr_word,
  input logic exec_valid,
  input logic op_valid,
  input logic [2:0] op_code,
  input logic skip_cond,
  input logic [PSQ_BRANCH_W-1:0] op_target,
  input logic [7:0] table_low_data,
  input logic table_low_we,
  input logic [NUM_IRQ-1:0] irq_req,
  input logic [NUM_IRQ-1:0] irq_en,
  input logic [NUM_IRQ-1:0] irq_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic bnd, quiet, pend;
  logic [13:0] ack_vec;
  assign bnd = exec_valid && phase_onehot[3] && op_valid;
  assign quiet = !pend && !(psel && penable && pwrite) && !(|(irq_req & irq_en));
  // A waiting page jump diverts the next boundary, so stepping is judged only without one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) pend <= 1'b0;
    else if (psel && penable && pwrite && paddr == 12'h018) pend <= 1'b1;
    else if (phase_onehot[3]) pend <= 1'b0;
  end
  always_comb begin
    ack_vec = 14'h0000;
    for (int i = 0; i < NUM_IRQ; i++) if (irq_ack[i]) ack_vec = 14'((i + 1) * 4);
  end
  a_phase_onehot: assert property ($onehot(phase_onehot)) else $error("phase not one-hot");
  a_phase_walk: assert property (nrst && phase_onehot[0] |=> phase_onehot[1] ##1 phase_onehot[2] ##1 phase_onehot[3])
    else $error("phase order broken");
  a_fetch_strobe: assert property (rom_rd == phase_onehot[0]) else $error("fetch strobe off phase");
  a_addr_steady: assert property (!phase_onehot[0] |-> $stable(rom_addr)) else $error("address moved");
  a_seq_step: assert property (exec_valid && phase_onehot[3] && !op_valid && quiet
    |=> rom_addr == $past(rom_addr) + 14'h1) else $error("no increment");
  a_skip_step: assert property (bnd && quiet && op_code == OP_SKIP
    |=> rom_addr == $past(rom_addr) + 14'h1 && exec_valid == !$past(skip_cond)) else $error("skip wrong");
  a_two_cycles: assert property (bnd && quiet && op_code != OP_NONE && op_code != OP_SKIP
    |=> !exec_valid [*4] ##1 exec_valid) else $error("transfer not two cycles");
  a_branch_addr: assert property (bnd && (op_code == OP_JUMP || op_code == OP_CALL)
    |=> rom_addr[12:0] == $past(op_target)) else $error("branch target wrong");
  a_last_page: assert property (bnd && op_code == OP_TABLE_LAST |=> rom_addr[13:8] == LAST_PAGE)
    else $error("last page not forced");
  a_ack_vector: assert property (irq_ack != 0 |-> $onehot(irq_ack) && rom_addr == ack_vec && !exec_valid)
    else $error("vector wrong");
  a_bus_answer: assert property (psel && penable
    |-> pready && pslverr == !(paddr inside {12'h010, 12'h018, 12'h01C, 12'h020, 12'h0C0, 12'h0C4}))
    else $error("bus answer wrong");
endmodule // psq_sequencer_properties
bind psq_sequencer psq_sequencer_properties #(.ADDR_W(ADDR_W), .NUM_IRQ(NUM_IRQ)) u_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rom_addr(rom_addr),
  .rom_rd(rom_rd),
  .rom_data(rom_data),
  .phase_onehot(phase_onehot),
  .instr_word(instr_word),
  .exec_valid(exec_valid),
  .op_valid(op_valid),
  .op_code(op_code),
  .skip_cond(skip_cond),
  .op_target(op_target),
  .table_low_data(table_low_data),
  .table_low_we(table_low_we),
  .irq_req(irq_req),
  .irq_en(irq_en),
  .irq_ack(irq_ack)
);

// File: sim/psq_sequencer_tb.sv
// Purpose: Self-checking bench for the program sequencer.
// Assumes: ROM model answers each fetch with {2'b10, address}.
// Notes: Scenario tasks drive ops, APB or interrupt levels, one or more of them each.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module psq_sequencer_tb
  import psq_pkg::*;
;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, rom_rd, exec_valid, op_valid, skip_cond;
  logic table_low_we, bus_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] rom_addr, pre;
  logic [15:0] rom_data, instr_word;
  logic [3:0] phase_onehot;
  logic [2:0] op_code;
  logic [12:0] op_target;
  logic [7:0] table_low_data;
  logic [5:0] irq_req, irq_en, irq_ack;
  int bad_count, comparisons;
  logic [13:0] vec [6] = '{VEC_EXT_IRQ0, VEC_TIMER0, VEC_TIMER1, VEC_EXT_IRQ1, VEC_UART, VEC_TIMER2};

  psq_sequencer uut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rom_addr(rom_addr),
    .rom_rd(rom_rd),
    .rom_data(rom_data),
    .phase_onehot(phase_onehot),
    .instr_word(instr_word),
    .exec_valid(exec_valid),
    .op_valid(op_valid),
    .op_code(op_code),
    .skip_cond(skip_cond),
    .op_target(op_target),
    .table_low_data(table_low_data),
    .table_low_we(table_low_we),
    .irq_req(irq_req),
    .irq_en(irq_en),
    .irq_ack(irq_ack)
  );
  psq_rom_model rom (
    .ref_clk(ref_clk),
    .rom_rd(rom_rd),
    .rom_addr(rom_addr),
    .rom_data(rom_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    bus_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Ops are held through phase 3 only, since the core may not repeat them
  task automatic op(input logic [2:0] code, input logic sk, input logic [12:0] tgt);
    do @(posedge ref_clk); while (!(exec_valid === 1'b1 && phase_onehot[2] === 1'b1));
    pre = rom_addr;
    op_valid <= 1'b1;
    op_code <= code;
    skip_cond <= sk;
    op_target <= tgt;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic step;
    do @(posedge ref_clk); while (phase_onehot[3] !== 1'b1);
    #1;
  endtask
  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (irq_ack === 6'h00 && n < 40);
  endtask
  task automatic t_boot;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(exec_valid, 1'b1)
    `CHK(rom_addr, 14'h0001)
    `CHK(instr_word, {2'b10, 14'h0000})
    apb(1'b1, 12'h020, 32'hFF);
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h03C, 32'h0);
    `CHK(bus_err, 1'b1)
  endtask
  task automatic t_branch;
    logic [13:0] saved_pc;
    apb(1'b1, 12'h010, 32'h20);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0000_0020)
    op(OP_JUMP, 1'b0, 13'h0123);
    `CHK(rom_addr, 14'h2123)
    `CHK(exec_valid, 1'b0)
    for (int k = 0; k < 2; k++) begin
      op(OP_CALL, 1'b0, 13'h0040);
      saved_pc = pre;
      `CHK(rom_addr, 14'h2040)
      op(k ? OP_RETURN_INT : OP_RETURN_SUB, 1'b0, 13'h0);
      `CHK(rom_addr, saved_pc)
    end
    apb(1'b1, 12'h010, 32'h0);
    op(OP_JUMP, 1'b0, 13'h1F00);
    `CHK(rom_addr, 14'h1F00)
  endtask
  task automatic t_skip;
    for (int s = 0; s < 2; s++) begin
      op(OP_SKIP, s[0], 13'h0);
      `CHK(rom_addr, pre + 14'h1)
      `CHK(exec_valid, ~s[0])
    end
  endtask
  task automatic t_short;
    apb(1'b1, 12'h018, 32'h5A);
    pre = rom_addr;
    step;
    `CHK(rom_addr, {pre[13:8], 8'h5A})
    apb(1'b0, 12'h0C4, 32'h0);
    `CHK(rd, {26'h0, pre[13:8]})
  endtask
  task automatic t_table;
    logic [5:0] page;
    apb(1'b1, 12'h01C, 32'h37);
    for (int k = 0; k < 2; k++) begin
      op(k ? OP_TABLE_LAST : OP_TABLE_CUR, 1'b0, 13'h0);
      page = k ? 6'h3F : pre[13:8];
      `CHK(rom_addr, {page, 8'h37})
      for (int n = 0; n < 12 && table_low_we !== 1'b1; n++) @(posedge ref_clk);
      `CHK(table_low_data, 8'h37)
      `CHK(instr_word, {2'b10, pre})
      `CHK(rom_addr, pre + 14'h1)
      apb(1'b0, 12'h020, 32'h0);
      `CHK(rd, {24'h0, 2'b10, page})
    end
  endtask
  task automatic t_irq;
    @(posedge ref_clk);
    irq_req <= 6'h3F;
    repeat (12) begin
      @(posedge ref_clk);
      `CHK(irq_ack, 6'h00)
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      irq_en <= 6'h01 << i;
      wait_ack;
      irq_en <= 6'h00;
      `CHK(irq_ack, 6'h01 << i)
      `CHK(rom_addr, vec[i])
      op(OP_RETURN_INT, 1'b0, 13'h0);
      // Let the return's dummy boundary pass before the next source is enabled
      step;
    end
  endtask
  task automatic t_full;
    repeat (16) op(OP_CALL, 1'b0, 13'h0200);
    apb(1'b0, 12'h0C0, 32'h0);
    `CHK(rd[4:0], 5'h10)
    @(posedge ref_clk);
    irq_en <= 6'h01;
    repeat (16) begin
      @(posedge ref_clk);
      `CHK(irq_ack, 6'h00)
    end
    op(OP_RETURN_SUB, 1'b0, 13'h0);
    wait_ack;
    `CHK(irq_ack, 6'h01)
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    irq_en <= 6'h00;
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(rom_addr, 14'h0000)
    `CHK(irq_ack, 6'h00)
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(rom_addr, 14'h0001)
  endtask
  initial begin
    #2000000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    op_valid = 1'b0;
    op_code = 3'h0;
    skip_cond = 1'b0;
    op_target = 13'h0;
    irq_req = 6'h00;
    irq_en = 6'h00;
    repeat (6) @(posedge ref_clk);
    `CHK(rom_addr, 14'h0000)
    nrst <= 1'b1;
    t_boot;
    t_branch;
    t_skip;
    t_short;
    t_table;
    t_irq;
    t_full;
    t_reset;
    finish_test;
  end
endmodule // psq_sequencer_tb
